// ==== crsx_pkg.sv ====
//------------------------------------------------------------------------------
// shared constants and types of the return/rotate/subtract/xor executor
//------------------------------------------------------------------------------
package crsx_pkg;

	// widths
	localparam int INSTR_W  = 14;                // instruction word width
	localparam int DATA_W   = 8;                 // data path width
	localparam int PC_W     = 13;                // program counter width
	localparam int FADDR_W  = 7;                 // file register address width
	localparam int FILE_N   = 128;               // file registers, 0 to 127
	localparam int SP_W     = 3;                 // stack pointer width
	localparam int STACK_N  = 8;                 // stack levels
	localparam int DIR_N    = 3;                 // direction registers 5 to 7
	localparam int RADDR_W  = 3;                 // register port address width

	// opcode masks and match values
	localparam logic [13:0] MSK_FULL       = 14'h3FFF;
	localparam logic [13:0] OPC_IRQ_RETURN = 14'h0009;
	localparam logic [13:0] OPC_SUB_RETURN = 14'h0008;
	localparam logic [13:0] OPC_OPTION     = 14'h0062;
	localparam logic [13:0] OPC_SLEEP      = 14'h0063;
	localparam logic [13:0] MSK_DIR        = 14'h3FF8;
	localparam logic [13:0] OPC_DIR        = 14'h0060;
	localparam logic [13:0] MSK_RET_LIT    = 14'h3C00;
	localparam logic [13:0] OPC_RET_LIT    = 14'h3400;
	localparam logic [13:0] MSK_FILE_OP    = 14'h3F00;
	localparam logic [13:0] OPC_ROT_RIGHT  = 14'h0C00;
	localparam logic [13:0] OPC_ROT_LEFT   = 14'h0D00;
	localparam logic [13:0] OPC_FILE_SUB   = 14'h0200;
	localparam logic [13:0] OPC_NIB_SWAP   = 14'h0E00;
	localparam logic [13:0] OPC_FILE_XOR   = 14'h0600;
	localparam logic [13:0] MSK_LIT_SUB    = 14'h3E00;
	localparam logic [13:0] OPC_LIT_SUB    = 14'h3C00;
	localparam logic [13:0] OPC_LIT_XOR    = 14'h3A00;

	// field positions and limits
	localparam int          DEST_BIT    = 7;     // destination select
	localparam int          IRQ_EN_BIT  = 7;     // global enable in irq control
	localparam logic [2:0]  DIR_SEL_MIN = 3'h5;  // lowest direction selector
	localparam logic [12:0] PC_STEP     = 13'h0001;
	localparam logic [2:0]  SP_STEP     = 3'h1;

	// reset values
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [7:0]  IRQCTL_RST   = 8'h00;
	localparam logic [7:0]  PRESCALE_RST = 8'hFF;
	localparam logic [7:0]  DIR_RST      = 8'hFF;
	localparam logic [12:0] PC_RST       = 13'h0000;

	// register port map
	localparam logic [2:0] REG_ACC      = 3'h0;
	localparam logic [2:0] REG_STATUS   = 3'h1;
	localparam logic [2:0] REG_IRQCTL   = 3'h2;
	localparam logic [2:0] REG_PRESCALE = 3'h3;
	localparam logic [2:0] REG_DIR5     = 3'h4;
	localparam logic [2:0] REG_DIR6     = 3'h5;
	localparam logic [2:0] REG_DIR7     = 3'h6;
	localparam logic [2:0] REG_PC_LO    = 3'h7;

	// status flags
	typedef struct packed {
		logic timeout_flag;
		logic power_down_flag;
		logic zero_flag;
		logic half_borrow_bit;
		logic carry_flag;
	} crsx_status_t;

	localparam crsx_status_t STATUS_RST = 5'h18;   // timeout and power-down high

	// sequencer states
	typedef enum logic [1:0] {
		CRSX_RUN   = 2'b00,
		CRSX_FLUSH = 2'b01,
		CRSX_SLEEP = 2'b10
	} crsx_state_t;

	// decoded operations
	typedef enum logic [3:0] {
		CRSX_OP_NONE     = 4'b0000,
		CRSX_OP_IRQ_RET  = 4'b0001,
		CRSX_OP_SUB_RET  = 4'b0010,
		CRSX_OP_RET_LIT  = 4'b0011,
		CRSX_OP_OPTION   = 4'b0100,
		CRSX_OP_DIR      = 4'b0101,
		CRSX_OP_SLEEP    = 4'b0110,
		CRSX_OP_ROT_R    = 4'b0111,
		CRSX_OP_ROT_L    = 4'b1000,
		CRSX_OP_FILE_SUB = 4'b1001,
		CRSX_OP_LIT_SUB  = 4'b1010,
		CRSX_OP_NIB_SWAP = 4'b1011,
		CRSX_OP_LIT_XOR  = 4'b1100,
		CRSX_OP_FILE_XOR = 4'b1101
	} crsx_op_t;

endpackage

// ==== crsx_exec.sv ====
//------------------------------------------------------------------------------
// Summary of operation
// - interrupt return pops stack, sets global enable
// - option load copies accumulator into prescale register
// - literal return loads accumulator, pops stack head
// - subroutine return pops stack, nothing else changes
// - seven-bit file address, destination bit picks target
// - rotate right through carry, only carry changes
// - rotate left through carry, only carry changes
// - sleep clears watchdog, sets timeout, clears power-down
// - sleep then halts the oscillator until the synchronised wake pin
// - literal minus accumulator into accumulator, flags updated
// - file minus accumulator routed by destination bit
// - subtract carry high means no borrow
// - nibble swap exchanges halves, no flags change
// - literal xor into accumulator, only zero changes
// - file xor routed by destination, only zero
// - direction load copies accumulator to register 5-7
//------------------------------------------------------------------------------
`timescale 1ns/1ps

module crsx_exec (
	input  wire logic                                  mclk,
	input  wire logic                                  rst_n,
	input  wire logic                                  ce,
	input  wire logic [crsx_pkg::INSTR_W-1:0]          instr,
	input  wire logic                                  instr_valid,
	input  wire logic                                  push_req,
	input  wire logic [crsx_pkg::PC_W-1:0]             push_addr,
	input  wire logic                                  wake_pin,
	input  wire logic [crsx_pkg::RADDR_W-1:0]          reg_addr,
	input  wire logic [crsx_pkg::DATA_W-1:0]           reg_wdata,
	input  wire logic                                  reg_wr,
	input  wire logic                                  reg_rd,
	output logic      [crsx_pkg::DATA_W-1:0]           reg_rdata,
	output logic      [crsx_pkg::PC_W-1:0]             pc,
	output logic      [crsx_pkg::DATA_W-1:0]           acc,
	output crsx_pkg::crsx_status_t                     status,
	output logic      [crsx_pkg::DATA_W-1:0]           irq_control_reg,
	output logic      [crsx_pkg::DATA_W-1:0]           prescale_cfg,
	output logic      [crsx_pkg::DIR_N-1:0][crsx_pkg::DATA_W-1:0] pin_direction_reg,
	output logic                                       watchdog_clear,
	output logic                                       osc_halt
);

	//--------------------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------------------
	crsx_pkg::crsx_state_t  state;                         // sequencer state
	crsx_pkg::crsx_op_t     op;                            // decoded operation
	logic [crsx_pkg::DATA_W-1:0] file_mem [crsx_pkg::FILE_N];   // file registers
	logic [crsx_pkg::PC_W-1:0]   stack_mem [crsx_pkg::STACK_N]; // return stack
	logic [crsx_pkg::SP_W-1:0]   stack_ptr;                // next free level
	logic [crsx_pkg::PC_W-1:0]   stack_head;               // newest entry
	logic                        wake_meta;                // first sync stage
	logic                        wake_sync;                // second sync stage
	logic                        exec;                     // instruction taken
	logic                        pop;                      // return executes
	logic                        to_file;                  // result to file
	logic                        to_acc;                   // result to acc
	logic [crsx_pkg::FADDR_W-1:0] faddr;                   // file address
	logic [crsx_pkg::DATA_W-1:0] fval;                     // file operand
	logic [crsx_pkg::DATA_W-1:0] lit;                      // literal operand
	logic [crsx_pkg::DATA_W-1:0] minuend;                  // subtract left side
	logic [crsx_pkg::DATA_W:0]   diff;                     // subtract with carry
	logic [4:0]                  nib_diff;                 // low nibble subtract
	logic [crsx_pkg::DATA_W-1:0] next_result;              // operation result
	crsx_pkg::crsx_status_t      next_status;              // flags after op
	logic [1:0]                  dir_idx;                  // direction select

	//--------------------------------------------------------------------------
	// wake pin synchroniser
	//--------------------------------------------------------------------------
	// two stages; only the second one is read by logic
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end else if (ce) begin
			wake_meta <= wake_pin;
			wake_sync <= wake_meta;
		end
	end

	//--------------------------------------------------------------------------
	// decode
	//--------------------------------------------------------------------------
	// match the word against each handled opcode; others pass as no-op
	always_comb begin
		op = crsx_pkg::CRSX_OP_NONE;
		if ((instr & crsx_pkg::MSK_FULL) == crsx_pkg::OPC_IRQ_RETURN) begin
			op = crsx_pkg::CRSX_OP_IRQ_RET;
		end else if ((instr & crsx_pkg::MSK_FULL) == crsx_pkg::OPC_SUB_RETURN) begin
			op = crsx_pkg::CRSX_OP_SUB_RET;
		end else if ((instr & crsx_pkg::MSK_FULL) == crsx_pkg::OPC_OPTION) begin
			op = crsx_pkg::CRSX_OP_OPTION;
		end else if ((instr & crsx_pkg::MSK_FULL) == crsx_pkg::OPC_SLEEP) begin
			op = crsx_pkg::CRSX_OP_SLEEP;
		end else if ((instr & crsx_pkg::MSK_DIR) == crsx_pkg::OPC_DIR
				&& instr[2:0] >= crsx_pkg::DIR_SEL_MIN) begin
			op = crsx_pkg::CRSX_OP_DIR;
		end else if ((instr & crsx_pkg::MSK_RET_LIT) == crsx_pkg::OPC_RET_LIT) begin
			op = crsx_pkg::CRSX_OP_RET_LIT;
		end else if ((instr & crsx_pkg::MSK_FILE_OP) == crsx_pkg::OPC_ROT_RIGHT) begin
			op = crsx_pkg::CRSX_OP_ROT_R;
		end else if ((instr & crsx_pkg::MSK_FILE_OP) == crsx_pkg::OPC_ROT_LEFT) begin
			op = crsx_pkg::CRSX_OP_ROT_L;
		end else if ((instr & crsx_pkg::MSK_FILE_OP) == crsx_pkg::OPC_FILE_SUB) begin
			op = crsx_pkg::CRSX_OP_FILE_SUB;
		end else if ((instr & crsx_pkg::MSK_FILE_OP) == crsx_pkg::OPC_NIB_SWAP) begin
			op = crsx_pkg::CRSX_OP_NIB_SWAP;
		end else if ((instr & crsx_pkg::MSK_FILE_OP) == crsx_pkg::OPC_FILE_XOR) begin
			op = crsx_pkg::CRSX_OP_FILE_XOR;
		end else if ((instr & crsx_pkg::MSK_LIT_SUB) == crsx_pkg::OPC_LIT_SUB) begin
			op = crsx_pkg::CRSX_OP_LIT_SUB;
		end else if ((instr & crsx_pkg::MSK_FILE_OP) == crsx_pkg::OPC_LIT_XOR) begin
			op = crsx_pkg::CRSX_OP_LIT_XOR;
		end
	end

	// operands and steering
	assign exec       = ce && instr_valid && (state == crsx_pkg::CRSX_RUN);
	assign pop        = (op == crsx_pkg::CRSX_OP_IRQ_RET) || (op == crsx_pkg::CRSX_OP_SUB_RET)
	                 || (op == crsx_pkg::CRSX_OP_RET_LIT);
	assign faddr      = instr[crsx_pkg::FADDR_W-1:0];
	assign fval       = file_mem[faddr];
	assign lit        = instr[crsx_pkg::DATA_W-1:0];
	assign stack_head = stack_mem[stack_ptr - crsx_pkg::SP_STEP];
	assign dir_idx    = 2'(instr[2:0] - crsx_pkg::DIR_SEL_MIN);

	// file ops go back to the file only with the destination bit set
	always_comb begin
		to_file = 1'b0;
		to_acc  = 1'b0;
		unique case (op)
			crsx_pkg::CRSX_OP_ROT_R, crsx_pkg::CRSX_OP_ROT_L,
			crsx_pkg::CRSX_OP_FILE_SUB, crsx_pkg::CRSX_OP_NIB_SWAP,
			crsx_pkg::CRSX_OP_FILE_XOR: begin
				to_file = instr[crsx_pkg::DEST_BIT];
				to_acc  = !instr[crsx_pkg::DEST_BIT];
			end
			crsx_pkg::CRSX_OP_RET_LIT, crsx_pkg::CRSX_OP_LIT_SUB,
			crsx_pkg::CRSX_OP_LIT_XOR: begin
				to_acc = 1'b1;
			end
			default: to_acc = 1'b0;
		endcase
	end

	//--------------------------------------------------------------------------
	// arithmetic
	//--------------------------------------------------------------------------
	// two's complement subtract: left + ~acc + 1, carry out means no borrow
	assign minuend  = (op == crsx_pkg::CRSX_OP_LIT_SUB) ? lit : fval;
	assign diff     = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
	assign nib_diff = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

	// result and flag update per operation
	always_comb begin
		next_result = acc;
		next_status = status;
		unique case (op)
			crsx_pkg::CRSX_OP_RET_LIT: begin
				next_result = lit;
			end
			crsx_pkg::CRSX_OP_ROT_R: begin
				next_result            = {status.carry_flag, fval[7:1]};
				next_status.carry_flag = fval[0];
			end
			crsx_pkg::CRSX_OP_ROT_L: begin
				next_result            = {fval[6:0], status.carry_flag};
				next_status.carry_flag = fval[7];
			end
			crsx_pkg::CRSX_OP_FILE_SUB, crsx_pkg::CRSX_OP_LIT_SUB: begin
				next_result                 = diff[7:0];
				next_status.carry_flag      = diff[8];
				next_status.half_borrow_bit = nib_diff[4];
				next_status.zero_flag       = (diff[7:0] == 8'h00);
			end
			crsx_pkg::CRSX_OP_NIB_SWAP: begin
				next_result = {fval[3:0], fval[7:4]};
			end
			crsx_pkg::CRSX_OP_LIT_XOR: begin
				next_result           = acc ^ lit;
				next_status.zero_flag = ((acc ^ lit) == 8'h00);
			end
			crsx_pkg::CRSX_OP_FILE_XOR: begin
				next_result           = acc ^ fval;
				next_status.zero_flag = ((acc ^ fval) == 8'h00);
			end
			crsx_pkg::CRSX_OP_SLEEP: begin
				next_status.timeout_flag    = 1'b1;
				next_status.power_down_flag = 1'b0;
			end
			default: next_result = acc;                        // returns keep flags
		endcase
	end

	//--------------------------------------------------------------------------
	// sequencer
	//--------------------------------------------------------------------------
	// returns spend one idle cycle, sleep waits for the wake pin
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= crsx_pkg::CRSX_RUN;
		end else if (ce) begin
			unique case (state)
				crsx_pkg::CRSX_RUN: begin
					if (exec && pop) begin
						state <= crsx_pkg::CRSX_FLUSH;
					end else if (exec && op == crsx_pkg::CRSX_OP_SLEEP) begin
						state <= crsx_pkg::CRSX_SLEEP;
					end
				end
				crsx_pkg::CRSX_FLUSH: begin
					state <= crsx_pkg::CRSX_RUN;               // prefetched word dropped
				end
				crsx_pkg::CRSX_SLEEP: begin
					if (wake_sync) begin
						state <= crsx_pkg::CRSX_RUN;
					end
				end
				default: begin
					state <= crsx_pkg::CRSX_RUN;               // illegal code recovers
				end
			endcase
		end
	end

	// oscillator halt and watchdog clear pulse
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			osc_halt       <= 1'b0;
			watchdog_clear <= 1'b0;
		end else if (ce) begin
			watchdog_clear <= exec && (op == crsx_pkg::CRSX_OP_SLEEP);
			if (exec && op == crsx_pkg::CRSX_OP_SLEEP) begin
				osc_halt <= 1'b1;
			end else if (state == crsx_pkg::CRSX_SLEEP && wake_sync) begin
				osc_halt <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------------------
	// program counter and stack
	//--------------------------------------------------------------------------
	// pops reload the counter from the stack head, others step it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pc        <= crsx_pkg::PC_RST;
			stack_ptr <= '0;
		end else if (ce) begin
			if (exec && pop) begin
				pc        <= stack_head;
				stack_ptr <= stack_ptr - crsx_pkg::SP_STEP;
			end else begin
				if (exec) begin
					pc <= pc + crsx_pkg::PC_STEP;
				end
				if (push_req) begin
					stack_ptr <= stack_ptr + crsx_pkg::SP_STEP;    // wraps at eight levels
				end
			end
		end
	end

	// stack storage, push ignored while a pop executes
	always_ff @(posedge mclk) begin
		if (ce && push_req && !(exec && pop)) begin
			stack_mem[stack_ptr] <= push_addr;
		end
	end

	//--------------------------------------------------------------------------
	// data state
	//--------------------------------------------------------------------------
	// file register write-back; reset clears it so file operands start known
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int j = 0; j < crsx_pkg::FILE_N; j++) begin
				file_mem[j] <= '0;                             // cleared file register
			end
		end else if (exec && to_file) begin
			file_mem[faddr] <= next_result;
		end
	end

	// accumulator and flags
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc    <= crsx_pkg::ACC_RST;
			status <= crsx_pkg::STATUS_RST;
		end else if (exec) begin
			if (to_acc) begin
				acc <= next_result;
			end
			status <= next_status;
		end
	end

	// irq control: instruction set wins over a port write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_control_reg <= crsx_pkg::IRQCTL_RST;
		end else if (ce) begin
			if (reg_wr && reg_addr == crsx_pkg::REG_IRQCTL) begin
				irq_control_reg <= reg_wdata;
			end
			if (exec && op == crsx_pkg::CRSX_OP_IRQ_RET) begin
				irq_control_reg[crsx_pkg::IRQ_EN_BIT] <= 1'b1;
			end
		end
	end

	// prescale configuration: legacy load or direct port write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prescale_cfg <= crsx_pkg::PRESCALE_RST;
		end else if (ce) begin
			if (exec && op == crsx_pkg::CRSX_OP_OPTION) begin
				prescale_cfg <= acc;
			end else if (reg_wr && reg_addr == crsx_pkg::REG_PRESCALE) begin
				prescale_cfg <= reg_wdata;                     // direct access path
			end
		end
	end

	// direction registers, one per selector
	for (genvar i = 0; i < crsx_pkg::DIR_N; i++) begin : g_dir
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				pin_direction_reg[i] <= crsx_pkg::DIR_RST;
			end else if (ce) begin
				if (exec && op == crsx_pkg::CRSX_OP_DIR && dir_idx == 2'(i)) begin
					pin_direction_reg[i] <= acc;
				end else if (reg_wr && reg_addr == 3'(crsx_pkg::REG_DIR5 + 3'(i))) begin
					pin_direction_reg[i] <= reg_wdata;
				end
			end
		end
	end

	//--------------------------------------------------------------------------
	// register read port
	//--------------------------------------------------------------------------
	// data valid the cycle after the read strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (ce) begin
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					crsx_pkg::REG_ACC:      reg_rdata <= acc;
					crsx_pkg::REG_STATUS:   reg_rdata <= {3'h0, status};
					crsx_pkg::REG_IRQCTL:   reg_rdata <= irq_control_reg;
					crsx_pkg::REG_PRESCALE: reg_rdata <= prescale_cfg;
					crsx_pkg::REG_DIR5:     reg_rdata <= pin_direction_reg[0];
					crsx_pkg::REG_DIR6:     reg_rdata <= pin_direction_reg[1];
					crsx_pkg::REG_DIR7:     reg_rdata <= pin_direction_reg[2];
					crsx_pkg::REG_PC_LO:    reg_rdata <= pc[7:0];
				endcase
			end
		end
	end

endmodule // crsx_exec

// ==== crsx_exec_asserts.sv ====
`timescale 1ns/1ps
//------------------------------------------
// port checker of the executor
//------------------------------------------
module crsx_exec_asserts (
	input wire logic                   mclk,
	input wire logic                   rst_n,
	input wire logic                   ce,
	input wire logic [13:0]            instr,
	input wire logic                   instr_valid,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	input wire logic [7:0]             acc,
	input wire crsx_pkg::crsx_status_t status,
	input wire logic [7:0]             irq_control_reg,
	input wire logic [7:0]             prescale_cfg,
	input wire logic                   watchdog_clear,
	input wire logic                   osc_halt
);
	logic flush;  // idle cycle after a return
	logic tk;     // word taken this cycle
	logic is_ret; // word is one of the returns
	// follow the idle cycle that trails every return
	always_ff @(posedge mclk) begin
		if (!rst_n)
			flush <= 1'b0;
		else if (ce)
			flush <= tk && is_ret;
	end
	assign tk = ce && instr_valid && !flush && !osc_halt;
	assign is_ret = instr == crsx_pkg::OPC_IRQ_RETURN || instr == crsx_pkg::OPC_SUB_RETURN
		|| (instr & crsx_pkg::MSK_RET_LIT) == crsx_pkg::OPC_RET_LIT;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// a taken word under a mask
	sequence op_s(logic [13:0] m, logic [13:0] v);
		tk && (instr & m) == v;
	endsequence
	sequence ret_s;
		tk && is_ret;
	endsequence
	sleep_entry_a: assert property (op_s(14'h3FFF, crsx_pkg::OPC_SLEEP) |=> watchdog_clear
		&& osc_halt && status.timeout_flag && !status.power_down_flag) else $error("sleep entry");
	wdog_pulse_a: assert property (watchdog_clear |=> !watchdog_clear) else $error("wdog pulse");
	irq_ret_a: assert property (op_s(14'h3FFF, crsx_pkg::OPC_IRQ_RETURN) |=> irq_control_reg[7]
		&& $stable(status)) else $error("irq return");
	sub_ret_a: assert property (op_s(14'h3FFF, crsx_pkg::OPC_SUB_RETURN) |=> $stable(acc)
		&& $stable(status)) else $error("sub return");
	option_load_a: assert property (op_s(14'h3FFF, crsx_pkg::OPC_OPTION) |=>
		prescale_cfg == $past(acc) && $stable(status)) else $error("option load");
	ret_lit_a: assert property (op_s(crsx_pkg::MSK_RET_LIT, crsx_pkg::OPC_RET_LIT) |=>
		acc == $past(instr[7:0]) && $stable(status)) else $error("literal return");
	ret_idle_a: assert property (ret_s |-> ##2 acc == $past(acc)) else $error("idle cycle");
	lit_sub_a: assert property (op_s(crsx_pkg::MSK_LIT_SUB, crsx_pkg::OPC_LIT_SUB) |=>
		acc == $past(instr[7:0]) - $past(acc) && status.carry_flag == ($past(instr[7:0]) >= $past(acc)))
		else $error("literal subtract");
	lit_xor_a: assert property (op_s(14'h3F00, crsx_pkg::OPC_LIT_XOR) |=> acc == ($past(acc)
		^ $past(instr[7:0])) && $stable(status.carry_flag)) else $error("literal xor");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data idle");
endmodule // crsx_exec_asserts

bind crsx_exec crsx_exec_asserts i_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .instr(instr),
	.instr_valid(instr_valid), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc(acc), .status(status),
	.irq_control_reg(irq_control_reg), .prescale_cfg(prescale_cfg),
	.watchdog_clear(watchdog_clear), .osc_halt(osc_halt));

// ==== cpu_return_rotate_sub_xor_exec_tb.sv ====
`timescale 1ns/1ps
module cpu_return_rotate_sub_xor_exec_tb;
	//------------------------------------------
	// stimulus and observed signals
	//------------------------------------------
	logic ce = 1'b1, rst_n = 1'b0, instr_valid = 1'b0, push_req = 1'b0, wake_pin = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, mclk = 1'b0, watchdog_clear, osc_halt;
	logic [13:0] instr = 14'h0000;
	logic [12:0] push_addr = 13'h0000, pc, p;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, acc, irq_control_reg, prescale_cfg, a, k, r;
	logic [4:0]  st;                     // status before an operation
	logic [2:0][7:0] pin_direction_reg;
	logic [7:0]  fm [128] = '{default: 8'h00}; // file register model, cleared like the design
	logic [6:0]  f;                      // file address under test
	crsx_pkg::crsx_status_t status;
	int err_total = 0, compares = 0, cyc = 0, i;
	crsx_exec i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .instr(instr), .instr_valid(instr_valid),
		.push_req(push_req), .push_addr(push_addr), .wake_pin(wake_pin), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc),
		.acc(acc), .status(status), .irq_control_reg(irq_control_reg), .prescale_cfg(prescale_cfg),
		.pin_direction_reg(pin_direction_reg), .watchdog_clear(watchdog_clear), .osc_halt(osc_halt));
	// 40 MHz clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	//------------------------------------------
	// expectations and checks
	//------------------------------------------
	function automatic logic [4:0] sub_st(logic [4:0] s, logic [7:0] kk, logic [7:0] aa);
		sub_st = {s[4:3], kk == aa, kk[3:0] >= aa[3:0], kk >= aa};
	endfunction
	function automatic logic [4:0] xor_st(logic [4:0] s, logic [7:0] v);
		xor_st = {s[4:3], v == 8'h00, s[1:0]};
	endfunction
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk13(input string n, input logic [12:0] e, input logic [12:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// one instruction word, then let the result settle
	task automatic ex(input logic [13:0] w);
		@(posedge mclk);
		instr <= w;
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic push(input logic [12:0] q);
		@(posedge mclk);
		push_req <= 1'b1;
		push_addr <= q;
		@(posedge mclk);
		push_req <= 1'b0;
	endtask
	// load acc by a literal return
	task automatic setacc(input logic [7:0] v);
		p = 13'($urandom);
		push(p);
		ex({6'h34, v});
		chk8("acc", v, acc);
		chk13("pc", p, pc);
	endtask
	task automatic rd(input logic [2:0] ad, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk8("reg", e, reg_rdata);
	endtask
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic summarize;
		$display("err_total=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end
	//------------------------------------------
	// main sequence
	//------------------------------------------
	initial begin
		void'($urandom(32'h186F));
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk8("status", 8'h18, {3'h0, status});
		rd(3'h3, 8'hFF);
		for (i = 4; i < 7; i++)
			rd(3'(i), 8'hFF);
		wr(3'h0, 8'h55);
		rd(3'h0, 8'h00);
		wr(3'h2, 8'h3C);
		rd(3'h2, 8'h3C);
		wr(3'h3, 8'hA5);
		rd(3'h3, 8'hA5);
		wr(3'h5, 8'h96);
		rd(3'h5, 8'h96);
		// subtract and xor, corners first
		for (i = 0; i < 24; i++) begin
			a = 8'($urandom);
			k = (i == 0) ? a : 8'($urandom);
			if (i == 1)
				a = 8'h01;
			if (i == 1)
				k = 8'h10;
			setacc(a);
			st = status;
			ex({6'h3C, k});
			r = k - a;
			chk8("sub", r, acc);
			chk8("subst", {3'h0, sub_st(st, k, a)}, {3'h0, status});
			st = sub_st(st, k, a);
			k = 8'($urandom);
			ex({6'h3A, k});
			chk8("xor", r ^ k, acc);
			chk8("xorst", {3'h0, xor_st(st, r ^ k)}, {3'h0, status});
		end
		ex(crsx_pkg::OPC_OPTION);
		chk8("option", r ^ k, prescale_cfg);
		for (i = 5; i < 8; i++) begin
			setacc(8'(i * 37));
			ex({11'h00C, 3'(i)});
			chk8("dir", 8'(i * 37), pin_direction_reg[i-5]);
		end
		// file operations against a model cleared at reset like the registers
		for (i = 0; i < 8; i++) begin
			f = 7'($urandom);
			a = 8'($urandom);
			setacc(a);
			st = status;
			ex({6'h06, 1'b1, f});
			fm[f] ^= a;
			chk8("fdest", a, acc);
			chk8("fxorst", {3'h0, xor_st(st, fm[f])}, {3'h0, status});
			st = xor_st(st, fm[f]);
			ex({6'h0E, 1'b0, f});
			k = {fm[f][3:0], fm[f][7:4]};
			chk8("swap", k, acc);
			ex({6'h02, 1'b1, f});
			st = sub_st(st, fm[f], k);
			fm[f] -= k;
			chk8("fsubst", {3'h0, st}, {3'h0, status});
			ex({6'h0C, 1'b0, f});
			r = {st[0], fm[f][7:1]};
			chk8("rrf", r, acc);
			k = fm[f];
			ex({6'h0D, 1'b1, f});
			fm[f] = {k[6:0], k[0]};
			st[0] = k[7];
			chk8("rlfst", {3'h0, st}, {3'h0, status});
			ex({6'h06, 1'b0, f});
			chk8("fxor", r ^ fm[f], acc);
		end
		wr(3'h2, 8'h00);
		push(13'h1ABC);
		ex(crsx_pkg::OPC_IRQ_RETURN);
		chk8("irq", 8'h80, irq_control_reg & 8'h80);
		chk13("pc", 13'h1ABC, pc);
		push(13'h0F0F);
		ex(crsx_pkg::OPC_SUB_RETURN);
		chk13("pc", 13'h0F0F, pc);
		// return, then a word in the idle cycle is dropped
		setacc(8'h5A);
		push(13'h0123);
		@(posedge mclk);
		instr <= crsx_pkg::OPC_SUB_RETURN;
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr <= {6'h3A, 8'hFF};
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
		chk8("flush", 8'h5A, acc);
		// clock enable low: an offered word must leave no trace
		@(posedge mclk);
		ce <= 1'b0;
		ex({6'h3A, 8'hFF});
		chk8("ce", 8'h5A, acc);
		@(posedge mclk);
		ce <= 1'b1;
		ex(crsx_pkg::OPC_SLEEP);
		chk8("sleep", 8'h0E, {4'h0, watchdog_clear, osc_halt, status[4:3]});
		ex({6'h3A, 8'hFF});
		chk8("asleep", 8'h5A, acc);
		@(posedge mclk);
		wake_pin <= 1'b1;
		for (i = 0; i < 8 && osc_halt !== 1'b0; i++)
			@(negedge mclk);
		chk8("wake", 8'h00, {7'h0, osc_halt});
		wake_pin <= 1'b0;
		summarize();
	end
endmodule // cpu_return_rotate_sub_xor_exec_tb
